// [hw/perf_event_counter_qualify.v]
// General event counters with legacy and full-width write paths,
// predefined event decoding and unit-mask qualification.
// Assumes event inputs come from core logic on mclk_i, except the
// stop-clock pin, which is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_counter_qualify_map.vh"

// Notes on behaviour
// - Write at ordinary counter address loads low data word sign-extended.
// - Capability register bit 13 reports full-width counter writes.
// - With that flag, counters also answer at alias addresses from 4C1H upward.
// - Alias write: bits 31:0 from low word, upper from high word truncated to implemented width.
// - One availability bit per predefined event, bits 0..6; set means missing.
// - Event 3CH/00H counts core cycles except sleep, halt, stop-clock, throttle, switch.
// - Core-cycle count keeps running across performance-state changes.
// - Event C0H/00H counts instructions at last micro-op; faulted ones not.
// - Retired count ignores VM exits but counts through interrupts and traps.
// - Event 3CH/01H counts fixed reference ticks while the core clock runs.
// - Event 2EH/4FH counts last-level-cache references, speculative and L1 prefetch.
// - Event 2EH/41H counts last-level-cache misses; other prefetch fills excluded.
// - Event C4H/00H counts branches when their last micro-op retires.
// - Event C5H/00H counts retired mispredicted branches on the architectural path.
// - Unit mask bits 15:8 carry qualification sub-fields for model-specific events.
// - Bits 15:14 pick core: 11 all, 01 this core, others reserved.
// - Bit 13 for agent events: 0 this agent only, 1 all agents.
// - Bits 13:12 prefetch: 11 all, 01 prefetch only, 00 exclude, 10 reserved.
// - Agent and prefetch qualification never together; core combines with either.
// - Bits 11..8 enable modified, exclusive, shared and invalid states.
// - Coherency-qualified event with all four state bits clear never counts.
// - Core-only events ignore core and agent specificity encodings.
// - Counting needs global enable and selector privilege enable both true.
module perf_event_counter_qualify #(
    parameter NUM_CTR = 2,                  // General counters
    parameter CTR_W = 48,                   // Implemented counter width, 33..64
    parameter FULL_WIDTH_WRITE = 1,         // Full-width write support
    parameter [6:0] EVT_UNAVAIL = 7'h00     // Missing predefined events
) (
    input wire mclk_i,                      // Core clock, 20 MHz
    input wire sys_rst_i,                   // Async reset, active high
    input wire reg_req_i,                   // Register access request
    input wire reg_we_i,                    // 1 write, 0 read
    input wire [11:0] reg_addr_i,           // Model-register address
    input wire [31:0] low_data_word_i,      // Write data bits 31:0
    input wire [31:0] high_data_word_i,     // Write data bits 63:32
    output reg reg_ack_o,                   // Access done pulse
    output reg reg_err_o,                   // Unmapped or refused access
    output reg [31:0] rd_low_o,             // Read data bits 31:0
    output reg [31:0] rd_high_o,            // Read data bits 63:32
    input wire [1:0] cpl_i,                 // Current privilege level
    input wire sleep_state_i,               // Sleep state other than C0
    input wire halted_i,                    // Halt instruction in effect
    input wire stop_clock_pin_i,            // Stop-clock pin, async
    input wire thermal_throttle_one_i,      // Thermal throttling active
    input wire freq_switch_i,               // Frequency-switch phase
    input wire retire_last_uop_i,           // Last micro-op of an instr retires
    input wire retire_fault_i,              // That instruction faulted
    input wire vm_exit_i,                   // Retirement is a VM exit
    input wire retire_branch_i,             // Retiring instr is a branch
    input wire retire_mispredict_i,         // Branch was mispredicted
    input wire llc_ref_i,                   // Core request hits LAST_LEVEL_CACHE lookup
    input wire llc_miss_i,                  // That request missed
    input wire llc_other_pf_i,              // Request is a non-L1 prefetch fill
    input wire ms_event_i,                  // Model-specific occurrence
    input wire [7:0] ms_code_i,             // Its event select code
    input wire ms_core_spec_i,              // Event supports core specificity
    input wire ms_agent_spec_i,             // Event supports agent specificity
    input wire ms_pf_qual_i,                // Event supports prefetch qualifier
    input wire ms_mesi_qual_i,              // Event needs coherency qualifier
    input wire ms_other_core_i,             // Occurrence came from another core
    input wire ms_other_agent_i,            // Occurrence came from another agent
    input wire ms_hw_pf_i,                  // Occurrence is a hardware prefetch
    input wire [3:0] ms_mesi_i,             // One-hot state: M,E,S,I in 3..0
    output wire [NUM_CTR-1:0] counting_o    // Counter advances at this edge unless written
);

    localparam [31:0] REF_DIV_FULL = `REF_DIV_CYCLES;
    localparam [7:0] REF_DIV = REF_DIV_FULL[7:0];

    reg stop_clock_pin_meta_q;
    reg stop_clock_pin_q;
    reg [7:0] ref_cnt_q;
    reg ref_tick_q;
    reg [NUM_CTR-1:0] glob_en_q;

    wire [NUM_CTR*CTR_W-1:0] cnt_flat;
    wire [NUM_CTR*32-1:0] sel_flat;

    wire core_run;
    wire instr_ev;

    wire [11:0] ctr_idx;
    wire [11:0] sel_idx;
    wire [11:0] alias_idx;

    wire ctr_hit;
    wire sel_hit;
    wire alias_hit;
    wire cap_hit;
    wire glob_hit;
    wire unav_hit;

    wire wr_req;
    wire [63:0] cap_val;

    // Stop-clock pin is asynchronous: two flops before anything reads it
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stop_clock_pin_meta_q <= 1'b0;
            stop_clock_pin_q <= 1'b0;
        end else begin
            stop_clock_pin_meta_q <= stop_clock_pin_i;
            stop_clock_pin_q <= stop_clock_pin_meta_q;
        end
    end

    // Core clock counted as running only outside all stall conditions
    assign core_run = ~sleep_state_i & ~halted_i & ~stop_clock_pin_q
        & ~thermal_throttle_one_i & ~freq_switch_i;

    // Reference tick from a fixed divider. mclk_i itself never changes
    // rate here, so the tick stays fixed whatever the performance state.
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref_cnt_q <= 8'h00;
            ref_tick_q <= 1'b0;
        end else if (ref_cnt_q == REF_DIV - 8'h01) begin
            ref_cnt_q <= 8'h00;
            ref_tick_q <= 1'b1;
        end else begin
            ref_cnt_q <= ref_cnt_q + 8'h01;
            ref_tick_q <= 1'b0;
        end
    end

    // Instruction counts once at its last micro-op, never on a fault or a
    // VM exit; interrupts and traps retire normally and do count
    assign instr_ev = retire_last_uop_i & ~retire_fault_i & ~vm_exit_i;

    // Address decode
    assign ctr_idx = reg_addr_i - `ADDR_CTR_BASE;
    assign sel_idx = reg_addr_i - `ADDR_SEL_BASE;
    assign alias_idx = reg_addr_i - `ADDR_ALIAS_BASE;
    assign ctr_hit = (reg_addr_i >= `ADDR_CTR_BASE) && (ctr_idx < NUM_CTR);
    assign sel_hit = (reg_addr_i >= `ADDR_SEL_BASE) && (sel_idx < NUM_CTR);
    // Alias addresses exist only when full-width writes are advertised
    assign alias_hit = (FULL_WIDTH_WRITE != 0) && (reg_addr_i >= `ADDR_ALIAS_BASE)
        && (alias_idx < NUM_CTR);
    assign cap_hit = (reg_addr_i == `ADDR_CAPABILITY);
    assign glob_hit = (reg_addr_i == `ADDR_GLOBAL_CTRL);
    assign unav_hit = (reg_addr_i == `ADDR_EVT_UNAVAIL);
    assign wr_req = reg_req_i & reg_we_i;

    // Capability word: only the full-width write flag is defined
    assign cap_val = (FULL_WIDTH_WRITE != 0) ? (64'h1 << `CAP_FULL_WIDTH_BIT)
        : 64'h0;

    // Global enable register, one bit per counter
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            glob_en_q <= {NUM_CTR{1'b0}};
        end else if (wr_req && glob_hit) begin
            glob_en_q <= low_data_word_i[NUM_CTR-1:0];
        end
    end

    // One counter and selector per channel
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CTR; gi = gi + 1) begin : g_ctr
            reg [CTR_W-1:0] cnt_q;
            reg [31:0] sel_q;

            wire [7:0] evsel;
            wire [7:0] umask;

            wire priv_ok;
            wire run_ok;

            wire core_ok;
            wire agent_ok;
            reg pf_ok;
            wire mesi_ok;
            wire ms_hit;
            reg ev_hit;

            wire wr_leg;
            wire wr_alias;

            assign evsel = sel_q[`SEL_EVENT_LO +: 8];
            assign umask = sel_q[`SEL_UMASK_LO +: 8];

            // Privilege enable: OS covers ring 0, USR covers rings above
            assign priv_ok = (cpl_i == 2'h0) ? sel_q[`SEL_OS_BIT]
                : sel_q[`SEL_USR_BIT];
            assign run_ok = glob_en_q[gi] & sel_q[`SEL_EN_BIT] & priv_ok;

            // Core specificity; reserved codes match nothing. Core-only
            // events do not flag support, so the bits are ignored.
            assign core_ok = ~ms_core_spec_i
                | (umask[`UM_CORE_LO +: 2] == `CORE_ALL)
                | ((umask[`UM_CORE_LO +: 2] == `CORE_THIS) & ~ms_other_core_i);

            // Agent specificity on bit 13
            assign agent_ok = ~ms_agent_spec_i | umask[`UM_AGENT_BIT]
                | ~ms_other_agent_i;

            // Prefetch qualifier shares bit 13 with the agent bit, so it is
            // decoded only for events without agent specificity
            always @* begin
                pf_ok = 1'b1;
                if (ms_pf_qual_i && !ms_agent_spec_i) begin
                    case (umask[`UM_PF_LO +: 2])
                        `PF_ALL: pf_ok = 1'b1;
                        `PF_ONLY: pf_ok = ms_hw_pf_i;
                        `PF_EXCLUDE: pf_ok = ~ms_hw_pf_i;
                        default: pf_ok = 1'b0;
                    endcase
                end
            end

            // Coherency state filter: no state bit set means nothing counts
            assign mesi_ok = ~ms_mesi_qual_i
                | (|(umask[`UM_MESI_LO +: 4] & ms_mesi_i));

            assign ms_hit = ms_event_i & (ms_code_i == evsel)
                & core_ok & agent_ok & pf_ok & mesi_ok;

            // Predefined events take their code pairs first; any other
            // select is matched against the model-specific source
            always @* begin
                ev_hit = 1'b0;
                if (evsel == `EV_CORE_CYC && umask == `UM_CORE_CYC) begin
                    ev_hit = core_run & ~EVT_UNAVAIL[0];
                end else if (evsel == `EV_INSTR && umask == `UM_INSTR) begin
                    ev_hit = instr_ev & ~EVT_UNAVAIL[1];
                end else if (evsel == `EV_REF_CYC && umask == `UM_REF_CYC) begin
                    ev_hit = ref_tick_q & core_run & ~EVT_UNAVAIL[2];
                end else if (evsel == `EV_LLC && umask == `UM_LLC_REF) begin
                    ev_hit = llc_ref_i & ~llc_other_pf_i & ~EVT_UNAVAIL[3];
                end else if (evsel == `EV_LLC && umask == `UM_LLC_MISS) begin
                    ev_hit = llc_ref_i & llc_miss_i & ~llc_other_pf_i
                        & ~EVT_UNAVAIL[4];
                end else if (evsel == `EV_BRANCH && umask == `UM_BRANCH) begin
                    ev_hit = instr_ev & retire_branch_i & ~EVT_UNAVAIL[5];
                end else if (evsel == `EV_BR_MISS && umask == `UM_BR_MISS) begin
                    ev_hit = instr_ev & retire_branch_i & retire_mispredict_i
                        & ~EVT_UNAVAIL[6];
                end else begin
                    ev_hit = ms_hit;
                end
            end

            assign counting_o[gi] = run_ok & ev_hit;
            assign wr_leg = wr_req & ctr_hit & (ctr_idx == gi);
            assign wr_alias = wr_req & alias_hit & (alias_idx == gi);

            // Counter: a write in the same cycle as an event wins, since
            // software expects to read back exactly what it loaded
            always @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    cnt_q <= {CTR_W{1'b0}};
                end else if (wr_leg) begin
                    cnt_q <= {{(CTR_W-32){low_data_word_i[31]}}, low_data_word_i};
                end else if (wr_alias) begin
                    cnt_q <= {high_data_word_i[CTR_W-33:0], low_data_word_i};
                end else if (counting_o[gi]) begin
                    cnt_q <= cnt_q + {{(CTR_W-1){1'b0}}, 1'b1};
                end
            end

            // Selector
            always @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    sel_q <= `SEL_RESET;
                end else if (wr_req && sel_hit && (sel_idx == gi)) begin
                    sel_q <= low_data_word_i;
                end
            end

            assign cnt_flat[gi*CTR_W +: CTR_W] = cnt_q;
            assign sel_flat[gi*32 +: 32] = sel_q;
        end
    endgenerate

    // Read data and answer, one cycle after the request. Counters read
    // back sign-extended from their implemented width, as they load.
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
            rd_low_o <= 32'h0000_0000;
            rd_high_o <= 32'h0000_0000;
        end else begin
            reg_ack_o <= reg_req_i;
            reg_err_o <= 1'b0;
            rd_low_o <= 32'h0000_0000;
            rd_high_o <= 32'h0000_0000;
            if (reg_req_i) begin
                if (ctr_hit || (alias_hit && reg_we_i)) begin
                    if (!reg_we_i) begin
                        rd_low_o <= cnt_flat[ctr_idx*CTR_W +: 32];
                        rd_high_o <= {{(64-CTR_W){cnt_flat[ctr_idx*CTR_W+CTR_W-1]}},
                            cnt_flat[ctr_idx*CTR_W+32 +: CTR_W-32]};
                    end
                end else if (alias_hit) begin
                    // Alias addresses are write paths only
                    reg_err_o <= 1'b1;
                end else if (sel_hit) begin
                    if (!reg_we_i) begin
                        rd_low_o <= sel_flat[sel_idx*32 +: 32];
                    end
                end else if (glob_hit) begin
                    if (!reg_we_i) begin
                        rd_low_o <= {{(32-NUM_CTR){1'b0}}, glob_en_q};
                    end
                end else if (cap_hit) begin
                    reg_err_o <= reg_we_i;
                    rd_low_o <= reg_we_i ? 32'h0000_0000 : cap_val[31:0];
                    rd_high_o <= reg_we_i ? 32'h0000_0000 : cap_val[63:32];
                end else if (unav_hit) begin
                    reg_err_o <= reg_we_i;
                    rd_low_o <= reg_we_i ? 32'h0000_0000
                        : {25'h0000000, EVT_UNAVAIL};
                end else begin
                    // Unmapped address, including aliases without support
                    reg_err_o <= 1'b1;
                end
            end
        end
    end

endmodule // perf_event_counter_qualify
`default_nettype wire

// [hw/perf_event_counter_qualify_map.vh]
// Constants for the qualified event counter: register addresses,
// selector field positions, event codes, reset values and timing.
// Assumes a 12-bit model-register address and 32-bit data words.
`ifndef PERF_EVENT_COUNTER_QUALIFY_MAP_VH
`define PERF_EVENT_COUNTER_QUALIFY_MAP_VH

// Register addresses (model-register numbers)
`define ADDR_CTR_BASE 12'h0c1
`define ADDR_SEL_BASE 12'h186
`define ADDR_ALIAS_BASE 12'h4c1
`define ADDR_CAPABILITY 12'h345
`define ADDR_GLOBAL_CTRL 12'h38f
`define ADDR_EVT_UNAVAIL 12'h0a0

// Capability register fields
`define CAP_FULL_WIDTH_BIT 13

// Event selector fields
`define SEL_EVENT_LO 0
`define SEL_UMASK_LO 8
`define SEL_USR_BIT 16
`define SEL_OS_BIT 17
`define SEL_EN_BIT 22
`define SEL_RESET 32'h0000_0000

// Unit-mask sub-fields, relative to the unit mask
`define UM_CORE_LO 6
`define UM_AGENT_BIT 5
`define UM_PF_LO 4
`define UM_MESI_LO 0

// Core and prefetch encodings
`define CORE_ALL 2'h3
`define CORE_THIS 2'h1
`define PF_ALL 2'h3
`define PF_ONLY 2'h1
`define PF_EXCLUDE 2'h0

// Predefined events: event select and unit mask
`define EV_CORE_CYC 8'h3c
`define UM_CORE_CYC 8'h00
`define EV_INSTR 8'hc0
`define UM_INSTR 8'h00
`define EV_REF_CYC 8'h3c
`define UM_REF_CYC 8'h01
`define EV_LLC 8'h2e
`define UM_LLC_REF 8'h4f
`define UM_LLC_MISS 8'h41
`define EV_BRANCH 8'hc4
`define UM_BRANCH 8'h00
`define EV_BR_MISS 8'hc5
`define UM_BR_MISS 8'h00
`define NUM_PREDEF 7

// Reference clock period in ns and core clock period in ns
`define REF_PERIOD_NS 100
`define MCLK_PERIOD_NS 50
`define REF_DIV_CYCLES (`REF_PERIOD_NS / `MCLK_PERIOD_NS)

`endif

// [tb/perf_event_counter_qualify_sva.sv]
// Checker for the qualified event counter: answer timing, read-back of
// counters after writes, capability and availability words.
// Assumes it is bound to perf_event_counter_qualify and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_counter_qualify_map.vh"
module perf_event_counter_qualify_sva #(
    parameter NUM_CTR = 2,
    parameter CTR_W = 48,
    parameter FULL_WIDTH_WRITE = 1,
    parameter [6:0] EVT_UNAVAIL = 7'h00
) (
    input wire logic mclk_i,                 // Core clock
    input wire logic sys_rst_i,              // Async reset
    input wire logic reg_req_i,              // Access request
    input wire logic reg_we_i,               // Write select
    input wire logic [11:0] reg_addr_i,      // Register address
    input wire logic [31:0] low_data_word_i, // Write data low
    input wire logic [31:0] high_data_word_i,// Write data high
    input wire logic reg_ack_o,              // Answer pulse
    input wire logic reg_err_o,              // Refusal flag
    input wire logic [31:0] rd_low_o,        // Read data low
    input wire logic [31:0] rd_high_o,       // Read data high
    input wire logic [NUM_CTR-1:0] counting_o // Per-counter advance
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // Expected upper words; the alias path only keeps the implemented width
    wire [31:0] lo_sx = {32{low_data_word_i[31]}};
    wire [31:0] hi_sx = {{(64-CTR_W){high_data_word_i[CTR_W-33]}}, high_data_word_i[CTR_W-33:0]};

    // Nothing may count before software ever touches the global enable
    logic glob_seen_q;
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            glob_seen_q <= 1'b0;
        else if (reg_req_i && reg_we_i && reg_addr_i == `ADDR_GLOBAL_CTRL)
            glob_seen_q <= 1'b1;
    end

    sequence s_rd(a);
        reg_req_i && !reg_we_i && reg_addr_i == a;
    endsequence
    sequence s_wr(a);
        reg_req_i && reg_we_i && reg_addr_i == a;
    endsequence

    a_ack_follows_req: assert property (reg_req_i |=> reg_ack_o)
        else $error("request not answered next cycle");
    a_no_stray_ack: assert property (!reg_req_i |=> !reg_ack_o && !reg_err_o)
        else $error("answer without request");
    a_idle_data_zero: assert property (!reg_ack_o |-> rd_low_o == 32'h0 && rd_high_o == 32'h0)
        else $error("read data not zero outside answer");
    a_cap_flag_read: assert property (s_rd(`ADDR_CAPABILITY) |=> rd_low_o[13] == (FULL_WIDTH_WRITE != 0))
        else $error("capability flag wrong");
    a_unavail_vector: assert property (s_rd(`ADDR_EVT_UNAVAIL) |=> rd_low_o[6:0] == EVT_UNAVAIL)
        else $error("availability vector wrong");
    a_alias_read_err: assert property (s_rd(`ADDR_ALIAS_BASE) |=> reg_err_o)
        else $error("alias read not refused");
    a_alias_write_ok: assert property (s_wr(`ADDR_ALIAS_BASE) |=> reg_ack_o && !reg_err_o)
        else $error("alias write refused");
    a_legacy_sext: assert property (s_wr(`ADDR_CTR_BASE) ##1 s_rd(`ADDR_CTR_BASE)
        |=> rd_low_o == $past(low_data_word_i, 2) && rd_high_o == $past(lo_sx, 2))
        else $error("legacy write not sign extended");
    a_alias_full: assert property (s_wr(`ADDR_ALIAS_BASE) ##1 s_rd(`ADDR_CTR_BASE)
        |=> rd_low_o == $past(low_data_word_i, 2) && rd_high_o == $past(hi_sx, 2))
        else $error("alias write value wrong");
    a_idle_no_count: assert property (!glob_seen_q |-> counting_o == '0)
        else $error("counting before global enable");
endmodule // perf_event_counter_qualify_sva

bind perf_event_counter_qualify perf_event_counter_qualify_sva #(.NUM_CTR(NUM_CTR),
    .CTR_W(CTR_W), .FULL_WIDTH_WRITE(FULL_WIDTH_WRITE), .EVT_UNAVAIL(EVT_UNAVAIL)) u_sva (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i), .reg_we_i(reg_we_i),
    .reg_addr_i(reg_addr_i), .low_data_word_i(low_data_word_i),
    .high_data_word_i(high_data_word_i), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
    .rd_low_o(rd_low_o), .rd_high_o(rd_high_o), .counting_o(counting_o));
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the qualified event counter: write paths,
// core-cycle stalls, privilege gating, predefined and qualified events.
// Assumes the design's default widths and the shared address map header.
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_counter_qualify_map.vh"
module testbench;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_req_i = 1'b0;
    logic reg_we_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] low_data_word_i = 32'h0;
    logic [31:0] high_data_word_i = 32'h0;
    logic [1:0] cpl_i = 2'h0;
    logic [4:0] stall = 5'h00;   // Stop-clock, switch, throttle, halt, sleep
    logic [19:0] ev = 20'h00000; // Retire, cache and model-specific inputs
    logic [7:0] ms_code_i = 8'h40;
    wire reg_ack_o;
    wire reg_err_o;
    wire [31:0] rd_low_o;
    wire [31:0] rd_high_o;
    wire [1:0] counting_o;
    logic [63:0] rd_q;
    logic err_q;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int i;
    int j;
    // Selector low half and expected count per predefined event
    logic [23:0] pre_tab [5] = '{24'h00c003, 24'h00c402, 24'h00c501, 24'h4f2e02, 24'h412e00};
    // Plain, faulted, VM exit, branch, mispredict, cache ref, miss, other prefetch
    logic [19:0] pulse_tab [8] = '{20'h80000, 20'hc0000, 20'ha0000, 20'h90000,
        20'h98000, 20'h04000, 20'h06000, 20'h07000};
    // Unit mask, attribute bits, code mismatch flag and expected count
    logic [23:0] ms_tab [17] = '{24'hc0c401, 24'h40c400, 24'h40c001, 24'h80c000,
        24'h00a200, 24'h20a201, 24'h109000, 24'h109101, 24'h009100, 24'h309101,
        24'h209100, 24'h008880, 24'h028821, 24'h048820, 24'h20b301, 24'h408401, 24'h008002};

    perf_event_counter_qualify #(.EVT_UNAVAIL(7'h10)) dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i), .reg_we_i(reg_we_i),
        .reg_addr_i(reg_addr_i), .low_data_word_i(low_data_word_i),
        .high_data_word_i(high_data_word_i), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
        .rd_low_o(rd_low_o), .rd_high_o(rd_high_o), .cpl_i(cpl_i),
        .sleep_state_i(stall[0]), .halted_i(stall[1]), .thermal_throttle_one_i(stall[2]),
        .freq_switch_i(stall[3]), .stop_clock_pin_i(stall[4]),
        .retire_last_uop_i(ev[19]), .retire_fault_i(ev[18]), .vm_exit_i(ev[17]),
        .retire_branch_i(ev[16]), .retire_mispredict_i(ev[15]), .llc_ref_i(ev[14]),
        .llc_miss_i(ev[13]), .llc_other_pf_i(ev[12]), .ms_event_i(ev[11]),
        .ms_code_i(ms_code_i), .ms_core_spec_i(ev[10]), .ms_agent_spec_i(ev[9]),
        .ms_pf_qual_i(ev[8]), .ms_mesi_qual_i(ev[7]), .ms_other_core_i(ev[6]),
        .ms_other_agent_i(ev[5]), .ms_hw_pf_i(ev[4]), .ms_mesi_i(ev[3:0]),
        .counting_o(counting_o));

    // Free-running core clock
    always #25 mclk_i = ~mclk_i;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    // One access; request stays up so calls may run back to back
    task automatic reg_op(input logic we, input logic [11:0] a, input logic [63:0] d);
        reg_req_i = 1'b1;
        reg_we_i = we;
        reg_addr_i = a;
        {high_data_word_i, low_data_word_i} = d;
        @(negedge mclk_i);
        rd_q = {rd_high_o, rd_low_o};
        err_q = reg_err_o;
        chk1("ack", 1'b1, reg_ack_o);
    endtask

    task automatic idle();
        reg_req_i = 1'b0;
        @(negedge mclk_i);
    endtask

    // Clear counter 0, program its selector and open the global enable
    task automatic win_open(input logic [31:0] sel);
        reg_op(1'b1, `ADDR_CTR_BASE, 64'h0);
        reg_op(1'b1, `ADDR_SEL_BASE, {32'h0, sel});
        reg_op(1'b1, `ADDR_GLOBAL_CTRL, 64'h1);
        reg_req_i = 1'b0;
    endtask

    // The closing write's own edge still counts, the read after it does not
    task automatic win_close(input string name, input logic [63:0] exp);
        reg_op(1'b1, `ADDR_GLOBAL_CTRL, 64'h0);
        reg_op(1'b0, `ADDR_CTR_BASE, 64'h0);
        idle();
        chk(name, exp, rd_q);
    endtask

    initial begin
        repeat (5) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        reg_op(1'b0, `ADDR_CAPABILITY, 64'h0);
        chk("cap_full_width", 64'h2000, rd_q);
        reg_op(1'b0, `ADDR_EVT_UNAVAIL, 64'h0);
        chk("unavail_vector", 64'h10, rd_q);
        reg_op(1'b0, `ADDR_ALIAS_BASE, 64'h0);
        chk1("alias_read_err", 1'b1, err_q);
        reg_op(1'b0, 12'h7ff, 64'h0);
        chk1("unmapped_err", 1'b1, err_q);
        reg_op(1'b1, `ADDR_CTR_BASE, 64'h1234_5678_8000_0001);
        reg_op(1'b0, `ADDR_CTR_BASE, 64'h0);
        chk("legacy_sext", 64'hffff_ffff_8000_0001, rd_q);
        reg_op(1'b1, `ADDR_ALIAS_BASE, 64'h0000_8001_0000_0005);
        reg_op(1'b0, `ADDR_CTR_BASE, 64'h0);
        chk("alias_negative", 64'hffff_8001_0000_0005, rd_q);
        reg_op(1'b1, `ADDR_ALIAS_BASE + 12'h1, 64'h1234_7fff_ffff_ffff);
        reg_op(1'b0, `ADDR_CTR_BASE + 12'h1, 64'h0);
        chk("alias_second", 64'h0000_7fff_ffff_ffff, rd_q);
        reg_op(1'b1, `ADDR_CAPABILITY, 64'h0);
        chk1("cap_write_err", 1'b1, err_q);
        idle();
        // Each stall source for three cycles; stop-clock lands two cycles late
        win_open(32'h0043_003c);
        for (i = 0; i < 5; i = i + 1) begin
            stall = 5'h01 << i;
            repeat (3) @(negedge mclk_i);
        end
        stall = 5'h00;
        repeat (5) @(negedge mclk_i);
        win_close("core_cycles", 64'd6);
        cpl_i = 2'h3;
        win_open(32'h0042_003c);
        repeat (4) @(negedge mclk_i);
        win_close("os_only_at_user", 64'h0);
        win_open(32'h0041_003c);
        repeat (4) @(negedge mclk_i);
        win_close("user_only_at_user", 64'd5);
        cpl_i = 2'h0;
        win_open(32'h0043_013c);
        repeat (5) @(negedge mclk_i);
        win_close("ref_cycles", 64'd3);
        for (i = 0; i < 5; i = i + 1) begin
            win_open({16'h0043, pre_tab[i][23:8]});
            for (j = 0; j < 8; j = j + 1) begin
                ev = pulse_tab[j];
                @(negedge mclk_i);
            end
            ev = 20'h0;
            win_close("predefined", {56'h0, pre_tab[i][7:0]});
        end
        for (i = 0; i < 17; i = i + 1) begin
            ms_code_i = ms_tab[i][1] ? 8'h41 : 8'h40;
            win_open({16'h0043, ms_tab[i][23:16], 8'h40});
            ev = {8'h00, ms_tab[i][15:4]};
            @(negedge mclk_i);
            ev = 20'h0;
            win_close("qualified", {63'h0, ms_tab[i][0]});
        end
        end_sim();
    end
endmodule // testbench
`default_nettype wire
